//--- core/itc_pkg.sv
package itc_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_PRESCALER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TICK0_CONTROL     = 4'h1;
  localparam logic [3:0] ADDR_TICK1_CONTROL     = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE        = 4'h3;
  localparam logic [3:0] ADDR_IRQ_FLAG          = 4'h4;
  localparam logic [3:0] ADDR_TIMER_GROUP       = 4'h5;

  // Field positions
  localparam int PSC_ON_BIT     = 2;
  localparam int PSC_SRC_LSB    = 0;
  localparam int TICK_RUN_BIT   = 7;
  localparam int TICK_PER_LSB   = 0;
  localparam int EN_GLOBAL_BIT  = 0;
  localparam int EN_GROUP_BIT   = 1;
  localparam int EN_LOWVOLT_BIT = 2;
  localparam int EN_TICK0_BIT   = 3;
  localparam int EN_TICK1_BIT   = 4;
  localparam int EN_SERIAL_BIT  = 5;
  localparam int EN_UART_BIT    = 6;
  localparam int GRP_CMPP_EN    = 0;
  localparam int GRP_CMPA_EN    = 1;
  localparam int GRP_CMPP_FLAG  = 4;
  localparam int GRP_CMPA_FLAG  = 5;

  // Reset values
  localparam logic [7:0] RESET_REG   = 8'h00;
  localparam logic [7:0] ENABLE_MASK = 8'h7F;
  localparam logic [7:0] GROUP_MASK  = 8'h33;

  // Prescaler source codes
  localparam logic [1:0] SRC_SYS      = 2'h0;
  localparam logic [1:0] SRC_SYS_DIV4 = 2'h1;
  localparam logic [1:0] SRC_SYS_DIV2 = 2'h2;
  localparam logic [1:0] SRC_SUB      = 2'h3;

  // Tick period base exponent
  localparam int TICK_BASE_EXP = 8;
  localparam int TICK_CNT_W    = 16;

  // Request sources, index = priority (0 highest)
  localparam int NUM_SRC  = 6;
  localparam int SRC_LVD  = 0;
  localparam int SRC_GRP  = 1;
  localparam int SRC_TB0  = 2;
  localparam int SRC_TB1  = 3;
  localparam int SRC_SER  = 4;
  localparam int SRC_UART = 5;

  // Vector addresses per source, arbitrary placement
  localparam logic [11:0] VEC_BASE = 12'h004;
  localparam logic [11:0] VEC_STEP = 12'h004;

  // Core handshake bundle
  typedef struct packed {
    logic        call;
    logic [11:0] vector;
    logic [2:0]  source;
  } itc_call_s;

  typedef struct packed {
    logic cmp_p;
    logic cmp_a;
    logic lowvolt;
    logic serial;
    logic uart;
  } itc_event_s;

endpackage

//--- core/itc_tick_gen.sv
module itc_tick_gen
  import itc_pkg::*;
#(
  parameter int CNT_W = TICK_CNT_W
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Control
  input  wire logic       run,
  input  wire logic       psc_tick,
  input  wire logic [2:0] period,
  // Result
  output logic            overflow
);

  // Elaboration guard: counter must hold the longest period
  if (CNT_W < TICK_BASE_EXP + 8) begin : g_bad_width
    $error("itc_tick_gen: CNT_W too small");
  end

  logic [CNT_W-1:0] count;
  logic             run_d;
  logic [CNT_W-1:0] last_cnt;

  // Terminal count for 2^(8+period) prescaled periods
  assign last_cnt = CNT_W'((32'h1 << (TICK_BASE_EXP + int'(period))) - 32'h1);

  // Run edge tracker
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) run_d <= 1'b0;
    else        run_d <= run;
  end

  // Counter restarts on switch-on; counts prescaled ticks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count    <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (!run || !run_d) begin
        count <= '0;
      end else if (psc_tick) begin
        if (count >= last_cnt) begin
          count    <= '0;
          overflow <= 1'b1;
        end else begin
          count <= count + CNT_W'(1);
        end
      end
    end
  end

endmodule

//--- core/itc_irq_control.sv
// Summary of operation
// - Timer compare call needs global, source, group enables and stack not full.
// - Group service clears global enable and group flag; software clears compare flags.
// - Low-voltage flag set by detector; calls when global and its enable set.
// - Low-voltage service clears its flag and global enable.
// - Each tick overflow sets its flag; calls its vector when enabled.
// - Tick service clears that tick flag and global enable.
// - Source field: 00 sys, 01 sys/4, 10 sys/2, 11 sub clock.
// - Prescaler enable bit 2 gates the prescaled clock.
// - Tick run bit 7 starts or stops generator; resets to zero.
// - Tick period field selects 2^(8+field) prescaled periods.
// - Serial flag set on byte done, address match or timeout; gated.
// - Serial service clears serial flag and global enable.
// - UART flag raised on any UART condition; gated by global, UART enables.
// - UART service clears UART flag and global enable, not UART status.
// - Any flag rising wakes the device regardless of enables.
// - Flags stay set until serviced or cleared by software.
// - Return-from-interrupt sets global enable; plain return leaves it clear.
// - Taking interrupt pushes program counter then loads vector.
// - Group flag set whenever any contained compare flag with its group enable set becomes set.
//
// The implementer's own choices: the plain strobed port and the address map.
module itc_irq_control
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Event inputs from peripherals, same clock
  input  wire itc_event_s  evt,
  // Sub clock, from another domain
  input  wire logic        sub_clk,
  // Core sequencer
  input  wire logic        stack_full,
  input  wire logic        call_ack,
  input  wire logic        ret_irq,
  output itc_call_s        call_req,
  // Power management
  output logic             wake
);

  // Elaboration guards: the source index is three bits wide and the
  // flag register maps exactly six sources into its low bits
  if (NUM_SRC > 8) begin : g_bad_src_width
    $error("itc_irq_control: NUM_SRC exceeds the source field");
  end
  if (NUM_SRC != 6) begin : g_bad_src_count
    $error("itc_irq_control: flag register layout needs six sources");
  end
  if (TICK_CNT_W < TICK_BASE_EXP + 8) begin : g_bad_tick_width
    $error("itc_irq_control: tick counter too narrow");
  end

  // Control registers
  logic       psc_on;
  logic [1:0] psc_src;
  logic       tb0_run;
  logic [2:0] tb0_per;
  logic       tb1_run;
  logic [2:0] tb1_per;
  logic [6:0] enables;
  logic [1:0] cmp_en;
  logic [1:0] cmp_flag;
  logic [NUM_SRC-1:0] flags;

  logic wr_psc;
  logic wr_tb0;
  logic wr_tb1;
  logic wr_en;
  logic wr_flag;
  logic wr_grp;

  assign wr_psc  = reg_wr && (reg_addr == ADDR_PRESCALER_CONTROL);
  assign wr_tb0  = reg_wr && (reg_addr == ADDR_TICK0_CONTROL);
  assign wr_tb1  = reg_wr && (reg_addr == ADDR_TICK1_CONTROL);
  assign wr_en   = reg_wr && (reg_addr == ADDR_IRQ_ENABLE);
  assign wr_flag = reg_wr && (reg_addr == ADDR_IRQ_FLAG);
  assign wr_grp  = reg_wr && (reg_addr == ADDR_TIMER_GROUP);

  // Prescaler and tick control registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      psc_on  <= 1'b0;
      psc_src <= SRC_SYS;
      tb0_run <= 1'b0;
      tb0_per <= 3'h0;
      tb1_run <= 1'b0;
      tb1_per <= 3'h0;
    end else begin
      if (wr_psc) begin
        psc_on  <= reg_wdata[PSC_ON_BIT];
        psc_src <= reg_wdata[PSC_SRC_LSB +: 2];
      end
      if (wr_tb0) begin
        tb0_run <= reg_wdata[TICK_RUN_BIT];
        tb0_per <= reg_wdata[TICK_PER_LSB +: 3];
      end
      if (wr_tb1) begin
        tb1_run <= reg_wdata[TICK_RUN_BIT];
        tb1_per <= reg_wdata[TICK_PER_LSB +: 3];
      end
    end
  end

  // Sub clock synchroniser and edge detect.
  // Only the second stage and its delayed copy feed logic; the third
  // flop exists for the edge compare and never sees the raw pin.
  logic sub_s1;
  logic sub_s2;
  logic sub_s3;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else begin
      sub_s1 <= sub_clk;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  // Fixed divider for sys/2 and sys/4 strobes.
  // Free running, so a source change takes effect within four cycles.
  logic [1:0] sys_div;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) sys_div <= 2'h0;
    else        sys_div <= sys_div + 2'h1;
  end

  // Prescaled clock strobe, gated by enable
  logic psc_tick;

  always_comb begin
    unique case (psc_src)
      SRC_SYS:      psc_tick = 1'b1;
      SRC_SYS_DIV4: psc_tick = (sys_div == 2'h3);
      SRC_SYS_DIV2: psc_tick = sys_div[0];
      SRC_SUB:      psc_tick = sub_s2 && !sub_s3;
    endcase
    if (!psc_on) psc_tick = 1'b0;
  end

  // Tick generators
  logic tb0_ovf;
  logic tb1_ovf;

  itc_tick_gen #(.CNT_W(TICK_CNT_W)) u_tick0 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .run      (tb0_run),
    .psc_tick (psc_tick),
    .period   (tb0_per),
    .overflow (tb0_ovf)
  );

  itc_tick_gen #(.CNT_W(TICK_CNT_W)) u_tick1 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .run      (tb1_run),
    .psc_tick (psc_tick),
    .period   (tb1_per),
    .overflow (tb1_ovf)
  );

  // Request arbitration
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] pending;
  logic [2:0]         win;
  logic               any_pend;
  logic               take;

  assign src_en[SRC_LVD]  = enables[EN_LOWVOLT_BIT];
  assign src_en[SRC_GRP]  = enables[EN_GROUP_BIT];
  assign src_en[SRC_TB0]  = enables[EN_TICK0_BIT];
  assign src_en[SRC_TB1]  = enables[EN_TICK1_BIT];
  assign src_en[SRC_SER]  = enables[EN_SERIAL_BIT];
  assign src_en[SRC_UART] = enables[EN_UART_BIT];
  assign pending = (enables[EN_GLOBAL_BIT] && !stack_full) ? (flags & src_en)
                                                             : '0;

  // Lowest index wins
  always_comb begin
    win      = 3'h0;
    any_pend = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win      = 3'(i);
        any_pend = 1'b1;
      end
    end
  end

  // Call request held until the core acknowledges.
  // The winner is frozen in call_src so that a higher priority request
  // arriving while the core is busy cannot change the vector under it;
  // it is picked up on the next arbitration once global is set again.
  logic       call_busy;
  logic [2:0] call_src;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      call_busy <= 1'b0;
      call_src  <= 3'h0;
    end else if (call_busy) begin
      if (call_ack) call_busy <= 1'b0;
    end else if (any_pend) begin
      call_busy <= 1'b1;
      call_src  <= win;
    end
  end

  // Core pushes the counter and jumps on ack
  assign take            = call_busy && call_ack;
  assign call_req.call   = call_busy;
  assign call_req.source = call_src;
  assign call_req.vector = VEC_BASE + VEC_STEP * {9'h000, call_src};

  // Global and per-source enables
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enables <= ENABLE_MASK[6:0] & RESET_REG[6:0];
      cmp_en  <= 2'h0;
    end else begin
      if (wr_en) enables <= reg_wdata[6:0];
      if (wr_grp) begin
        cmp_en[0] <= reg_wdata[GRP_CMPP_EN];
        cmp_en[1] <= reg_wdata[GRP_CMPA_EN];
      end
      if (take) enables[EN_GLOBAL_BIT] <= 1'b0;
      else if (ret_irq) enables[EN_GLOBAL_BIT] <= 1'b1;
    end
  end

  // Timer compare flags, cleared only by software
  logic [1:0] cmp_set;
  assign cmp_set = {evt.cmp_a, evt.cmp_p};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmp_flag <= 2'h0;
    end else begin
      if (wr_grp) begin
        cmp_flag[0] <= reg_wdata[GRP_CMPP_FLAG];
        cmp_flag[1] <= reg_wdata[GRP_CMPA_FLAG];
      end
      cmp_flag <= (wr_grp ? {reg_wdata[GRP_CMPA_FLAG], reg_wdata[GRP_CMPP_FLAG]}
                          : cmp_flag) | cmp_set;
    end
  end

  // Group raises when an enabled compare flag rises
  logic [1:0] cmp_rise;
  assign cmp_rise = cmp_set & ~cmp_flag & cmp_en;

  // Request flags: sets win over service and software clear
  logic [NUM_SRC-1:0] flag_set;
  logic [NUM_SRC-1:0] next_flags;

  assign flag_set[SRC_LVD]  = evt.lowvolt;
  assign flag_set[SRC_GRP]  = |cmp_rise;
  assign flag_set[SRC_TB0]  = tb0_ovf;
  assign flag_set[SRC_TB1]  = tb1_ovf;
  assign flag_set[SRC_SER]  = evt.serial;
  assign flag_set[SRC_UART] = evt.uart;

  // One next-value slice per source.
  // Software write replaces the flag, service clears the served one,
  // and a hardware set in the same cycle always wins so no event is lost.
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_flag
    logic sw_val;
    logic svc_clr;

    assign sw_val        = wr_flag ? reg_wdata[s] : flags[s];
    assign svc_clr       = take && (call_src == 3'(s));
    assign next_flags[s] = flag_set[s] || (sw_val && !svc_clr);
  end

  // Flag bank register

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) flags <= '0;
    else        flags <= next_flags;
  end

  // Wake pulse on any flag rising, enables ignored.
  // Compare flags count too: a masked group source still wakes.
  // A flag already high cannot rise, which is how software masks a source.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wake <= 1'b0;
    else        wake <= |(next_flags & ~flags) || |(cmp_set & ~cmp_flag);
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= RESET_REG;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PRESCALER_CONTROL: reg_rdata <= {5'h00, psc_on, psc_src};
        ADDR_TICK0_CONTROL:     reg_rdata <= {tb0_run, 4'h0, tb0_per};
        ADDR_TICK1_CONTROL:     reg_rdata <= {tb1_run, 4'h0, tb1_per};
        ADDR_IRQ_ENABLE:        reg_rdata <= {1'b0, enables};
        ADDR_IRQ_FLAG:          reg_rdata <= {2'h0, flags};
        ADDR_TIMER_GROUP:       reg_rdata <= {2'h0, cmp_flag, 2'h0, cmp_en};
        default:                reg_rdata <= RESET_REG;
      endcase
    end else begin
      reg_rdata <= RESET_REG;
    end
  end

endmodule

//--- tb/itc_irq_chk.sv
module itc_irq_chk
  import itc_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Events, core link, power
  input wire itc_event_s evt,
  input wire logic       sub_clk,
  input wire logic       stack_full,
  input wire logic       call_ack,
  input wire logic       ret_irq,
  input wire itc_call_s  call_req,
  input wire logic       wake
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Call handshake with the core
  a_call_hold: assert property (call_req.call && !call_ack |=> call_req.call)
    else $error("call dropped before ack");
  a_call_drop: assert property (call_req.call && call_ack |=> !call_req.call [*2])
    else $error("call not cleared after ack");
  a_fall_cause: assert property ($fell(call_req.call) |-> $past(call_ack))
    else $error("call fell without ack");
  a_vec_map: assert property (call_req.call |->
    call_req.vector == VEC_BASE + VEC_STEP * 12'(call_req.source))
    else $error("vector does not match source");
  a_vec_stable: assert property (call_req.call && !call_ack |=> $stable(call_req.vector))
    else $error("vector changed while pending");
  a_full_block: assert property ($rose(call_req.call) |-> !$past(stack_full))
    else $error("call taken with stack full");
  // Unused register bits
  a_psc_read: assert property (reg_rd && reg_addr == ADDR_PRESCALER_CONTROL
    |=> reg_rdata[7:3] == 5'h00)
    else $error("prescaler unused bits set");
  a_tick_read: assert property (reg_rd && (reg_addr == ADDR_TICK0_CONTROL
    || reg_addr == ADDR_TICK1_CONTROL) |=> reg_rdata[6:3] == 4'h0)
    else $error("tick unused bits set");

  c_call: cover property ($rose(call_req.call));
  c_wake: cover property (wake);
  c_tick1: cover property (call_req.call && call_req.source == 3'(SRC_TB1));
endmodule

bind itc_irq_control itc_irq_chk i_itc_irq_chk (.*);

//--- tb/itc_core_model.sv
module itc_core_model
  import itc_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // Request and answer
  input wire itc_call_s   call_req,
  input wire logic [3:0]  ack_delay,
  output logic            call_ack,
  // Record of taken calls
  output logic [2:0]      last_src,
  output logic [11:0]     last_vec,
  output int              n_calls
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_cnt;

  // Push PC and load vector after a set delay; no nested calls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      call_ack <= 1'b0;
      last_src <= 3'h0;
      last_vec <= 12'h000;
      n_calls  <= 0;
    end else begin
      call_ack <= 1'b0;
      if (call_req.call && !call_ack) begin
        if (wait_cnt == ack_delay) begin
          call_ack <= 1'b1;
          wait_cnt <= 4'h0;
          last_src <= call_req.source;
          last_vec <= call_req.vector;
          n_calls  <= n_calls + 1;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

//--- tb/testbench.sv
module testbench
  import itc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0, rst_b = 1'b0, sub_clk = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, stack_full = 1'b0, ret_irq = 1'b0;
  logic [3:0]  reg_addr = 4'h0, ack_delay = 4'h3;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        call_ack, wake;
  logic [2:0]  last_src;
  logic [11:0] last_vec;
  itc_event_s  evt = '0;
  itc_call_s   call_req;
  int          n_calls, n_wake = 0, cyc = 0, t_call = 0, t_prev = 0, k;
  int          failures = 0, n_tests = 0;
  logic [7:0]  psc [5] = '{8'h04, 8'h06, 8'h05, 8'h07, 8'h04};
  int          spc [5] = '{256, 512, 1024, 1024, 512};
  int          ord [4] = '{SRC_LVD, SRC_GRP, SRC_SER, SRC_UART};

  itc_irq_control i_itc_irq_control (.*);
  itc_core_model i_itc_core_model (.*);

  // Clocks: system 40 MHz, sub clock 4 cycles per period
  always #12.5 clk_sys = ~clk_sys;
  initial #7 forever #50 sub_clk = ~sub_clk;

  // Cycle and wake counters
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
  end

  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
  endtask

  task ev(input logic [4:0] m);
    @(posedge clk_sys);
    evt <= itc_event_s'(m);
    @(posedge clk_sys);
    evt <= '0;
  endtask

  task ret;
    @(posedge clk_sys);
    ret_irq <= 1'b1;
    @(posedge clk_sys);
    ret_irq <= 1'b0;
  endtask

  task wait_call(input int s);
    k = n_calls;
    repeat (3000) if (n_calls == k) @(posedge clk_sys);
    chk("call count", 12'h001, 12'(n_calls - k));
    chk("call source", 12'(s), {9'h0, last_src});
    chk("call vector", VEC_BASE + VEC_STEP * 12'(s), last_vec);
    t_prev = t_call;
    t_call = cyc;
  endtask

  task finish_test;
    $display("Checks %0d, errors %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values, unmapped reads, field widths
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
    wr(ADDR_PRESCALER_CONTROL, 8'hFF);
    rd(ADDR_PRESCALER_CONTROL, 8'h07);
    wr(ADDR_TICK1_CONTROL, 8'hFF);
    rd(ADDR_TICK1_CONTROL, 8'h87);
    wr(ADDR_TICK1_CONTROL, 8'h00);
    wr(ADDR_PRESCALER_CONTROL, 8'h00);
    wr(4'hA, 8'hFF);
    rd(4'hA, 8'h00);
    // Low-voltage request, wake, service, return
    wr(ADDR_IRQ_ENABLE, 8'h04);
    k = n_wake;
    ev(5'h04);
    repeat (4) @(posedge clk_sys);
    chk("wake count", 12'h001, 12'(n_wake - k));
    rd(ADDR_IRQ_FLAG, 8'h01);
    wr(ADDR_IRQ_ENABLE, 8'h05);
    wait_call(SRC_LVD);
    rd(ADDR_IRQ_FLAG, 8'h00);
    rd(ADDR_IRQ_ENABLE, 8'h04);
    ret;
    rd(ADDR_IRQ_ENABLE, 8'h05);
    // Preset flag masks wake
    wr(ADDR_IRQ_ENABLE, 8'h00);
    wr(ADDR_IRQ_FLAG, 8'h01);
    repeat (4) @(posedge clk_sys);
    k = n_wake;
    ev(5'h04);
    repeat (4) @(posedge clk_sys);
    chk("wake count", 12'h000, 12'(n_wake - k));
    wr(ADDR_IRQ_FLAG, 8'h00);
    // Grouped compare, stack full, priority order
    wr(ADDR_IRQ_ENABLE, 8'h7E);
    wr(ADDR_TIMER_GROUP, 8'h01);
    ev(5'h08);
    rd(ADDR_IRQ_FLAG, 8'h00);
    rd(ADDR_TIMER_GROUP, 8'h21);
    ev(5'h17);
    rd(ADDR_IRQ_FLAG, 8'h33);
    @(posedge clk_sys);
    stack_full <= 1'b1;
    k = n_calls;
    wr(ADDR_IRQ_ENABLE, 8'h7F);
    repeat (10) @(posedge clk_sys);
    chk("calls with stack full", 12'h000, 12'(n_calls - k));
    stack_full <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wait_call(ord[i]);
      ret;
    end
    rd(ADDR_IRQ_FLAG, 8'h00);
    rd(ADDR_TIMER_GROUP, 8'h31);
    wr(ADDR_TIMER_GROUP, 8'h00);
    // Tick periods for each prescaler source
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_IRQ_ENABLE, i == 4 ? 8'h11 : 8'h09);
      wr(ADDR_PRESCALER_CONTROL, psc[i]);
      wr(i == 4 ? ADDR_TICK1_CONTROL : ADDR_TICK0_CONTROL, i == 4 ? 8'h81 : 8'h80);
      wait_call(i == 4 ? SRC_TB1 : SRC_TB0);
      rd(ADDR_IRQ_FLAG, 8'h00);
      ret;
      wait_call(i == 4 ? SRC_TB1 : SRC_TB0);
      chk("tick spacing", 12'(spc[i]), 12'(t_call - t_prev));
      wr(i == 4 ? ADDR_TICK1_CONTROL : ADDR_TICK0_CONTROL, 8'h00);
      ret;
      wr(ADDR_IRQ_FLAG, 8'h00);
    end
    // Prescaler off stops ticks, tick0 fully enabled
    wr(ADDR_IRQ_ENABLE, 8'h09);
    wr(ADDR_PRESCALER_CONTROL, 8'h00);
    wr(ADDR_TICK0_CONTROL, 8'h80);
    k = n_calls;
    repeat (600) @(posedge clk_sys);
    chk("calls while gated", 12'h000, 12'(n_calls - k));
    finish_test;
  end
endmodule
